// File: rtl/fws_defs.vh
// Constants of the flash write-status polling controller.
`ifndef FWS_DEFS_VH
`define FWS_DEFS_VH
// Avalon register word indices; byte address is four times the index.
`define FWS_REG_CTRL      2'h0
`define FWS_REG_ADDR      2'h1
`define FWS_REG_DATA      2'h2
`define FWS_REG_STATUS    2'h3
// Control register fields.
`define FWS_CTRL_START    0
`define FWS_CTRL_ERASE    1
`define FWS_CTRL_ABORT    2
// Status register fields.
`define FWS_ST_BUSY       0
`define FWS_ST_DONE       1
`define FWS_ST_FAIL       2
`define FWS_ST_TIMEOUT    3
`define FWS_ST_TIMER      4
// Data bit positions of the status flags.
`define FWS_POLL_BIT      7
`define FWS_TOGGLE_BIT    6
`define FWS_LIMIT_BIT     5
`define FWS_TIMER_BIT     3
`define FWS_SECTOR_BIT    2
// Command byte of the single-cycle reset sequence.
`define FWS_RESET_CMD     8'hF0
// Bus timing: read or write strobe low time and recovery, in ns.
`define FWS_STROBE_NS     100
`define FWS_RECOVER_NS    50
`define FWS_CLK_NS        50
`define FWS_STROBE_CYC    ((`FWS_STROBE_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_RECOVER_CYC   ((`FWS_RECOVER_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
// Poll limit in status evaluations of five cycles each (default about 100 ms at 20 MHz).
`define FWS_POLL_LIMIT    400000
`endif

// File: rtl/fws_poller.v
// Host controller that polls a flash bank's write-status flags to completion.
//
// Contract
// - Host polls erase status at an erasing sector address.
// - Bit 7 may turn valid early; host rereads all bits.
// - Host raises a strobe whenever bank address changes.
// - Host issues reset command after exceeded-limit failure; the poller sends it only when software writes the abort bit.
`timescale 1ns/1ns
`include "fws_defs.vh"
module fws_poller #(
    parameter ADDR_W     = 22,
    parameter POLL_LIMIT = `FWS_POLL_LIMIT
) (
    input  wire               I_CLK,
    input  wire               I_RST,
    input  wire [1:0]         I_AVS_ADDRESS,
    input  wire               I_AVS_READ,
    input  wire               I_AVS_WRITE,
    input  wire [31:0]        I_AVS_WRITEDATA,
    output reg  [31:0]        O_AVS_READDATA,
    output reg                O_AVS_WAITREQUEST,
    output reg  [ADDR_W-1:0]  O_FL_ADDR,
    input  wire [7:0]         I_FL_DQ,
    output reg  [7:0]         O_FL_DQ,
    output reg                O_FL_DQ_OE,
    output reg                O_FL_CE_N,
    output reg                O_FL_OE_N,
    output reg                O_FL_WE_N
);

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam S_IDLE  = 3'h0;
    localparam S_RD1   = 3'h1;
    localparam S_RD2   = 3'h2;
    localparam S_EVAL  = 3'h3;
    localparam S_RDC   = 3'h4;
    localparam S_WR    = 3'h5;
    localparam S_DONE  = 3'h6;

    localparam [7:0]  STROBE_CYC  = `FWS_STROBE_CYC;
    localparam [7:0]  RECOVER_CYC = `FWS_RECOVER_CYC;
    localparam [18:0] LIMIT       = POLL_LIMIT;

    reg [2:0]        state_reg;
    reg [7:0]        tmr_reg;
    reg              phase_reg;
    reg [18:0]       poll_cnt_reg;
    reg [ADDR_W-1:0] addr_reg;
    reg [7:0]        data_reg;
    reg              erase_reg;
    reg [7:0]        first_reg;
    reg [7:0]        second_reg;
    reg              busy_reg;
    reg              done_reg;
    reg              fail_reg;
    reg              timeout_reg;
    reg              timer_reg;
    reg              start_req_reg;
    reg              abort_req_reg;

    // ------------------------------------------------------------
    // Flag decoding
    // ------------------------------------------------------------
    // True when two consecutive reads differ in the toggle bit.
    function toggling;
        input [7:0] a;
        input [7:0] b;
        begin
            toggling = a[`FWS_TOGGLE_BIT] ^ b[`FWS_TOGGLE_BIT];
        end
    endfunction

    // True when bit 7 shows the expected completion value.
    function poll_done;
        input [7:0] d;
        input       ers;
        input [7:0] wr;
        begin
            if (ers) begin
                poll_done = d[`FWS_POLL_BIT];
            end else begin
                poll_done = d[`FWS_POLL_BIT] == wr[`FWS_POLL_BIT];
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Avalon slave
    // ------------------------------------------------------------
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_AVS_WAITREQUEST <= 1'b1;
            O_AVS_READDATA    <= 32'h0;
            addr_reg          <= {ADDR_W{1'b0}};
            data_reg          <= 8'h0;
            erase_reg         <= 1'b0;
            start_req_reg     <= 1'b0;
            abort_req_reg     <= 1'b0;
        end else begin
            start_req_reg <= 1'b0;
            abort_req_reg <= 1'b0;
            if ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST) begin
                O_AVS_WAITREQUEST <= 1'b0;
                if (I_AVS_WRITE) begin
                    case (I_AVS_ADDRESS)
                        `FWS_REG_CTRL: begin
                            if (!busy_reg) begin
                                start_req_reg <= I_AVS_WRITEDATA[`FWS_CTRL_START];
                                abort_req_reg <= I_AVS_WRITEDATA[`FWS_CTRL_ABORT];
                                erase_reg     <= I_AVS_WRITEDATA[`FWS_CTRL_ERASE];
                            end
                        end
                        `FWS_REG_ADDR: addr_reg <= I_AVS_WRITEDATA[ADDR_W-1:0];
                        `FWS_REG_DATA: data_reg <= I_AVS_WRITEDATA[7:0];
                        default: ;
                    endcase
                end else begin
                    case (I_AVS_ADDRESS)
                        `FWS_REG_CTRL:
                            O_AVS_READDATA <= {30'h0, erase_reg, 1'b0};
                        `FWS_REG_ADDR:
                            O_AVS_READDATA <= {{(32-ADDR_W){1'b0}}, addr_reg};
                        `FWS_REG_DATA:
                            O_AVS_READDATA <= {16'h0, second_reg, data_reg};
                        default:
                            O_AVS_READDATA <= {27'h0, timer_reg, timeout_reg,
                                               fail_reg, done_reg, busy_reg};
                    endcase
                end
            end else begin
                O_AVS_WAITREQUEST <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Polling sequencer
    // ------------------------------------------------------------
    // Each flash cycle: strobe low for STROBE_CYC, then all strobes high for
    // at least RECOVER_CYC, so chip and output enable toggle between every read.
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            state_reg    <= S_IDLE;
            tmr_reg      <= 8'h0;
            phase_reg    <= 1'b0;
            poll_cnt_reg <= 19'h0;
            first_reg    <= 8'h0;
            second_reg   <= 8'h0;
            busy_reg     <= 1'b0;
            done_reg     <= 1'b0;
            fail_reg     <= 1'b0;
            timeout_reg  <= 1'b0;
            timer_reg    <= 1'b0;
            O_FL_ADDR    <= {ADDR_W{1'b0}};
            O_FL_DQ      <= 8'h0;
            O_FL_DQ_OE   <= 1'b0;
            O_FL_CE_N    <= 1'b1;
            O_FL_OE_N    <= 1'b1;
            O_FL_WE_N    <= 1'b1;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (abort_req_reg) begin
                        busy_reg  <= 1'b1;
                        phase_reg <= 1'b0;
                        tmr_reg   <= 8'h0;
                        state_reg <= S_WR;
                    end else if (start_req_reg) begin
                        busy_reg     <= 1'b1;
                        done_reg     <= 1'b0;
                        fail_reg     <= 1'b0;
                        timeout_reg  <= 1'b0;
                        poll_cnt_reg <= 19'h0;
                        O_FL_ADDR    <= addr_reg;
                        phase_reg    <= 1'b0;
                        tmr_reg      <= 8'h0;
                        state_reg    <= S_RD1;
                    end
                end
                S_RD1, S_RD2, S_RDC: begin
                    tmr_reg <= tmr_reg + 8'h01;
                    if (!phase_reg) begin
                        O_FL_CE_N <= 1'b0;
                        O_FL_OE_N <= 1'b0;
                        if (tmr_reg == STROBE_CYC) begin
                            if (state_reg == S_RD1) begin
                                first_reg <= I_FL_DQ;
                            end else begin
                                second_reg <= I_FL_DQ;
                            end
                            O_FL_CE_N <= 1'b1;
                            O_FL_OE_N <= 1'b1;
                            phase_reg <= 1'b1;
                            tmr_reg   <= 8'h0;
                        end
                    end else if (tmr_reg == RECOVER_CYC - 8'h01) begin
                        phase_reg <= 1'b0;
                        tmr_reg   <= 8'h0;
                        case (state_reg)
                            S_RD1:   state_reg <= S_RD2;
                            S_RD2:   state_reg <= S_EVAL;
                            default: state_reg <= S_DONE;
                        endcase
                    end
                end
                S_EVAL: begin
                    poll_cnt_reg <= poll_cnt_reg + 19'h00001;
                    timer_reg    <= second_reg[`FWS_TIMER_BIT];
                    if (!toggling(first_reg, second_reg) &&
                        poll_done(second_reg, erase_reg, data_reg)) begin
                        state_reg <= S_RDC;
                    end else if (second_reg[`FWS_LIMIT_BIT]) begin
                        // Recheck: toggling may have stopped as the limit bit rose.
                        first_reg <= second_reg;
                        if (first_reg[`FWS_LIMIT_BIT]) begin
                            fail_reg  <= 1'b1;
                            busy_reg  <= 1'b0;
                            state_reg <= S_IDLE;
                        end else begin
                            state_reg <= S_RD2;
                        end
                    end else if (poll_cnt_reg == LIMIT - 19'h00001) begin
                        timeout_reg <= 1'b1;
                        busy_reg    <= 1'b0;
                        state_reg   <= S_IDLE;
                    end else begin
                        first_reg <= second_reg;
                        state_reg <= S_RD2;
                    end
                end
                S_WR: begin
                    tmr_reg    <= tmr_reg + 8'h01;
                    O_FL_DQ    <= `FWS_RESET_CMD;
                    O_FL_DQ_OE <= 1'b1;
                    if (!phase_reg) begin
                        O_FL_CE_N <= 1'b0;
                        O_FL_WE_N <= 1'b0;
                        if (tmr_reg == STROBE_CYC) begin
                            O_FL_CE_N <= 1'b1;
                            O_FL_WE_N <= 1'b1;
                            phase_reg <= 1'b1;
                            tmr_reg   <= 8'h0;
                        end
                    end else if (tmr_reg == RECOVER_CYC - 8'h01) begin
                        O_FL_DQ_OE <= 1'b0;
                        phase_reg  <= 1'b0;
                        busy_reg   <= 1'b0;
                        fail_reg   <= 1'b0;
                        state_reg  <= S_IDLE;
                    end
                end
                S_DONE: begin
                    done_reg  <= 1'b1;
                    busy_reg  <= 1'b0;
                    state_reg <= S_IDLE;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

endmodule

// File: sim/fws_poller_props.sv
// Port-level checks of the write-status poller.
`timescale 1ns/1ns
module fws_poller_props #(
    parameter ADDR_W = 22
) (
    input logic              I_CLK,
    input logic              I_RST,
    input logic [1:0]        I_AVS_ADDRESS,
    input logic              I_AVS_READ,
    input logic              I_AVS_WRITE,
    input logic [31:0]       I_AVS_WRITEDATA,
    input logic [31:0]       O_AVS_READDATA,
    input logic              O_AVS_WAITREQUEST,
    input logic [ADDR_W-1:0] O_FL_ADDR,
    input logic [7:0]        I_FL_DQ,
    input logic [7:0]        O_FL_DQ,
    input logic              O_FL_DQ_OE,
    input logic              O_FL_CE_N,
    input logic              O_FL_OE_N,
    input logic              O_FL_WE_N
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    sequence s_rd_pulse;
        !O_FL_OE_N ##1 !O_FL_OE_N ##1 O_FL_OE_N;
    endsequence
    sequence s_wr_pulse;
        !O_FL_WE_N ##1 !O_FL_WE_N ##1 O_FL_WE_N;
    endsequence
    a_wait_one: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
        else $error("waitrequest low too long");
    a_req_answer: assert property ($rose(I_AVS_READ) || $rose(I_AVS_WRITE)
        |=> !O_AVS_WAITREQUEST) else $error("request not answered");
    a_read_len: assert property ($fell(O_FL_OE_N) |-> s_rd_pulse)
        else $error("read strobe length wrong");
    a_write_len: assert property ($fell(O_FL_WE_N) |-> s_wr_pulse)
        else $error("write strobe length wrong");
    a_reset_data: assert property (!O_FL_WE_N |-> O_FL_DQ_OE && O_FL_DQ == 8'hF0)
        else $error("reset command data wrong");
    a_read_undriven: assert property (!O_FL_OE_N |-> !O_FL_DQ_OE && !O_FL_CE_N)
        else $error("read without select or with drive");
    a_addr_quiet: assert property ($changed(O_FL_ADDR) |-> O_FL_CE_N && O_FL_OE_N)
        else $error("address changed under strobe");
    a_oe_we_excl: assert property (O_FL_OE_N || O_FL_WE_N)
        else $error("read and write strobes together");
endmodule
bind fws_poller fws_poller_props #(.ADDR_W(ADDR_W)) u_props (
    .I_CLK(I_CLK), .I_RST(I_RST), .I_AVS_ADDRESS(I_AVS_ADDRESS),
    .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
    .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
    .O_FL_ADDR(O_FL_ADDR), .I_FL_DQ(I_FL_DQ), .O_FL_DQ(O_FL_DQ), .O_FL_DQ_OE(O_FL_DQ_OE),
    .O_FL_CE_N(O_FL_CE_N), .O_FL_OE_N(O_FL_OE_N), .O_FL_WE_N(O_FL_WE_N));

// File: sim/fws_flash_model.sv
// Behavioural flash bank that reports write-status flags on reads.
`timescale 1ns/1ns
module fws_flash_model (
    input  wire        i_ce_n,
    input  wire        i_oe_n,
    input  wire        i_we_n,
    input  wire [21:0] i_addr,
    input  wire [7:0]  i_dq,
    output wire [7:0]  o_dq
);
    reg [1:0] mode;
    reg [7:0] dat;
    reg [7:0] pd;
    reg [7:0] q;
    reg       tog;
    reg       tog2;
    reg       sus;
    reg       rst_seen;
    integer   left;
    // A read or a command write counts only while chip enable is low as well.
    wire      rd_on = !i_oe_n && !i_ce_n;
    wire      wr_on = !i_we_n && !i_ce_n;
    initial begin
        mode = 2'h0;
        dat = 8'hFF;
        pd = 8'hFF;
        q = 8'h00;
        tog = 1'b0;
        tog2 = 1'b1;
        sus = 1'b0;
        rst_seen = 1'b0;
        left = 0;
    end
    // Mode 1 programs, 2 erases, 3 is stuck past its limit; reads left ends the run.
    task arm(input [1:0] m, input integer n, input [7:0] d);
        begin
            arm_prot(m, n, d, d);
        end
    endtask
    // A protected target shows status for n reads and then keeps its old contents.
    task arm_prot(input [1:0] m, input integer n, input [7:0] old, input [7:0] d);
        begin
            mode = m;
            left = n;
            dat = old;
            pd = d;
            sus = 1'b0;
            rst_seen = 1'b0;
        end
    endtask
    always @(posedge rd_on) begin
        if (mode == 2'h0 || i_addr[21]) begin
            q = dat;
        end else if (sus) begin
            tog2 = ~tog2;
            q = {2'b11, 3'b000, tog2, 2'b01};
        end else begin
            tog = ~tog;
            if (mode == 2'h2) tog2 = ~tog2;
            q = {(mode == 2'h2) ? 1'b0 : ~pd[7], tog, mode == 2'h3, 1'b0, mode == 2'h2,
                 (mode == 2'h2) ? tog2 : 1'b1, 2'b01};
            if (mode != 2'h3) left = left - 1;
            if (mode != 2'h3 && left <= 0) mode = 2'h0;
        end
    end
    // The command is latched as the first of write or chip enable rises.
    always @(negedge wr_on) begin
        if (i_dq == 8'hF0) begin
            mode = 2'h0;
            sus = 1'b0;
            rst_seen = 1'b1;
        end
    end
    // Outside a read the released bus shows the inverse of the last byte.
    assign o_dq = rd_on ? q : ~q;
endmodule

// File: sim/tb_top.sv
// Self-checking testbench of the write-status poller.
`timescale 1ns/1ns
`include "fws_defs.vh"
`define CHK(a, e) begin checks = checks + 1; if ((a) !== (e)) begin failures = failures + 1; \
    $display("BAD %0t %h %h", $time, a, e); end end
module tb_top;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         rd = 1'b0;
    reg         wr = 1'b0;
    reg  [1:0]  adr = 2'h0;
    reg  [31:0] wd = 32'h0;
    reg  [31:0] rdat;
    wire [31:0] rdata;
    wire        wreq, doe, ce_n, oe_n, we_n;
    wire [21:0] fa;
    wire [7:0]  dq_o, dev_dq;
    wire [7:0]  fdq = doe ? dq_o : dev_dq;
    integer     failures = 0, checks = 0, n, m;
    initial forever #25 clk = ~clk;
    fws_poller #(.POLL_LIMIT(20)) uut (.I_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(adr),
        .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(wreq), .O_FL_ADDR(fa), .I_FL_DQ(fdq), .O_FL_DQ(dq_o),
        .O_FL_DQ_OE(doe), .O_FL_CE_N(ce_n), .O_FL_OE_N(oe_n), .O_FL_WE_N(we_n));
    fws_flash_model dev (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(fa),
        .i_dq(fdq), .o_dq(dev_dq));
    task end_of_test;
        begin
            $display("checks %0d failures %0d", checks, failures);
            if (failures == 0 && checks > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task bus(input w, input [1:0] a, input [31:0] d);
        begin
            @(posedge clk); rd <= !w; wr <= w; adr <= a; wd <= d; n = 0;
            do begin @(posedge clk); n = n + 1; end while (wreq !== 1'b0 && n < 100);
            rdat = rdata; rd <= 1'b0; wr <= 1'b0;
            if (n >= 100) begin failures = failures + 1; end_of_test; end
        end
    endtask
    task run(input [31:0] ctrl);
        begin
            bus(1'b1, `FWS_REG_CTRL, ctrl); m = 0; repeat (2) @(posedge clk);
            do begin bus(1'b0, `FWS_REG_STATUS, 0); m = m + 1; end
            while (rdat[`FWS_ST_BUSY] !== 1'b0 && m < 500);
            if (m >= 500) begin failures = failures + 1; end_of_test; end
        end
    endtask
    task rcmd;
        begin
            run(32'h4);
            `CHK(dev.rst_seen, 1'b1)
            `CHK(rdat[2], 1'b0)
        end
    endtask
    task sc_regs;
        begin
            bus(1'b0, `FWS_REG_STATUS, 0);
            `CHK(rdat[4:0], 5'h00)
            bus(1'b1, `FWS_REG_CTRL, 32'h2);
            bus(1'b0, `FWS_REG_CTRL, 0);
            `CHK(rdat[1], 1'b1)
        end
    endtask
    task sc_prog;
        begin
            dev.arm(2'h1, 5, 8'hA5);
            bus(1'b1, `FWS_REG_DATA, 32'hA5);
            bus(1'b1, `FWS_REG_ADDR, 32'h100);
            run(32'h1);
            `CHK(rdat[4:0], 5'h02)
            bus(1'b0, `FWS_REG_DATA, 0);
            `CHK(rdat[15:8], 8'hA5)
        end
    endtask
    task sc_erase;
        begin
            dev.arm(2'h2, 6, 8'hFF);
            run(32'h3);
            `CHK(rdat[4:0], 5'h12)
            bus(1'b0, `FWS_REG_DATA, 0);
            `CHK(rdat[15:8], 8'hFF)
        end
    endtask
    task sc_fail;
        begin
            dev.arm(2'h3, 0, 8'hA5);
            run(32'h1);
            `CHK(rdat[2], 1'b1)
            rcmd;
        end
    endtask
    task sc_tmo;
        begin
            dev.arm(2'h1, 100000, 8'hA5);
            run(32'h1);
            `CHK(rdat[3:2], 2'b10)
            rcmd;
        end
    endtask
    // Protected target: status stops, old contents stay, bit 7 never matches.
    task sc_prot(input [1:0] md);
        begin
            bus(1'b1, `FWS_REG_DATA, 32'hA5);
            dev.arm_prot(md, 3, 8'h5A, 8'hA5);
            run({30'h0, md == 2'h2, 1'b1});
            `CHK(rdat[3:2], 2'b10)
            bus(1'b0, `FWS_REG_DATA, 0);
            `CHK(rdat[15:8], 8'h5A)
        end
    endtask
    task sc_susp;
        begin
            dev.arm(2'h2, 100, 8'hFF);
            dev.sus = 1'b1;
            run(32'h3);
            `CHK(rdat[4:0], 5'h02)
            bus(1'b0, `FWS_REG_DATA, 0);
            `CHK(rdat[15:14], 2'b11)
            rcmd;
        end
    endtask
    // Polling a non-busy bank sees array data at once, never status.
    task sc_bank;
        begin
            dev.arm(2'h1, 100, 8'h3C);
            bus(1'b1, `FWS_REG_DATA, 32'h3C);
            bus(1'b1, `FWS_REG_ADDR, 32'h200100);
            run(32'h1);
            `CHK(rdat[4:0], 5'h12)
            rcmd;
        end
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        sc_regs;
        sc_prog;
        sc_erase;
        sc_fail;
        sc_tmo;
        sc_prot(2'h1);
        sc_prot(2'h2);
        sc_susp;
        sc_bank;
        end_of_test;
    end
endmodule
